//--- amcf_adc_model.sv
/* Converter model for the analog module bench.
   Assumes adc_start is a one-cycle pulse on the rising edge of clk. */
`default_nettype none
module amcf_adc_model #(
    parameter int CONV = 8
) (
    input  wire logic        clk,
    input  wire logic        adc_start,
    input  wire logic [2:0]  adc_chan,
    output logic      [11:0] adc_result
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] val_r = 12'h000;  // Result of the running conversion.
    int          cnt_r = 0;        // Cycles left while the result holds.
    // A fresh result per start, held a little past the conversion time.
    always_ff @(posedge clk) begin
        if (adc_start) begin
            val_r <= {adc_chan, 9'h1a5};
            cnt_r <= CONV + 2;
        end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
        end
    end
    // Outside a conversion the lines show junk, never the old result.
    assign adc_result = (cnt_r > 0) ? val_r : ~val_r;
endmodule : amcf_adc_model
`default_nettype wire

//--- amcf_pkg.sv
/*
 * Constants and types for the analog module configuration and data word
 * formatting block: register offsets, field positions, timing and states.
 * Assumes a 40 MHz system clock and an AXI4-Lite master with 32-bit data.
 */
`default_nettype none

package amcf_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int AMCF_CLK_PERIOD_NS = 25;      // System clock period.
    localparam int AMCF_CONV_TIME_NS  = 149000;  // One input conversion.
    localparam int AMCF_CONV_CYCLES   = AMCF_CONV_TIME_NS / AMCF_CLK_PERIOD_NS;
    localparam int AMCF_CNT_W         = 13;      // Conversion counter width.

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam int          AMCF_ADDR_W       = 8;
    localparam logic [7:0]  AMCF_OFS_CFG      = 8'h00; // Latched setup.
    localparam logic [7:0]  AMCF_OFS_STATUS   = 8'h04; // Live status.
    localparam logic [7:0]  AMCF_OFS_OUT      = 8'h08; // Output word.
    localparam logic [7:0]  AMCF_OFS_IRQ_STAT = 8'h0c; // Sticky events.
    localparam logic [7:0]  AMCF_OFS_IRQ_CLR  = 8'h10; // Write one clears.
    localparam logic [7:0]  AMCF_OFS_IRQ_EN   = 8'h14; // Event enables.
    localparam logic [7:0]  AMCF_OFS_IN_BASE  = 8'h20; // Input word 0.
    localparam logic [7:0]  AMCF_OFS_IN_LAST  = 8'h3c; // Input word 7.
    localparam int          AMCF_IDX_LSB      = 2;     // Word index bit.

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int AMCF_CFG_SW_LSB   = 0;   // Six latched switches.
    localparam int AMCF_CFG_VAR_LSB  = 8;   // Latched variant strap.
    localparam int AMCF_CFG_UNI_BIT  = 12;  // Unipolar range.
    localparam int AMCF_CFG_WIDE_BIT = 13;  // Wider range.
    localparam int AMCF_CFG_GAIN_LSB = 16;  // Gain select.
    localparam int AMCF_CFG_ATT_LSB  = 20;  // Attenuation one-hot.
    localparam int AMCF_CFG_CUR_LSB  = 24;  // Per-channel current mode.
    localparam int AMCF_ST_SUPPLY    = 0;   // Supply good.
    localparam int AMCF_ST_BUSY      = 1;   // Conversion running.
    localparam int AMCF_ST_CFG       = 2;   // Switches latched.
    localparam int AMCF_IRQ_W        = 2;
    localparam int AMCF_IRQ_CONV     = 0;   // Conversion finished.
    localparam int AMCF_IRQ_SUPPLY   = 1;   // Supply lost.
    localparam int AMCF_CUR_CH_A     = 6;
    localparam int AMCF_CUR_CH_B     = 7;
    localparam int AMCF_DAC_LSB      = 4;   // Dropped output bits.

    localparam logic [1:0] AMCF_RESP_OKAY   = 2'h0;
    localparam logic [1:0] AMCF_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AMCF_VAR_IN4   = 2'h0,
        AMCF_VAR_IN8   = 2'h1,
        AMCF_VAR_COMBO = 2'h2
    } amcf_variant_type;

    typedef enum logic [1:0] {
        AMCF_GAIN_LOW  = 2'h0,
        AMCF_GAIN_MID  = 2'h1,
        AMCF_GAIN_HIGH = 2'h2
    } amcf_gain_type;

    typedef enum logic [1:0] {
        AMCF_ST_IDLE = 2'b01,
        AMCF_ST_CONV = 2'b10
    } amcf_conv_state_type;

endpackage : amcf_pkg

`default_nettype wire

//--- amcf_top.sv
/*
 * Configuration latch, range decode, input and output word formatting,
 * supply monitor and AXI4-Lite register slave of an analog I/O module.
 * Assumes all inputs synchronous to clk and an ADC whose result is valid
 * by the end of the conversion time after adc_start.
 */
// Notes on behaviour
// - Switches sampled once after reset, then frozen.
// - One common range for all channels.
// - Four-input: switches a-c give range.
// - Eight-input: switches c-e give range.
// - Eight-input: switches a,b set current mode.
// - Combo: f polarity, d-e gain, a-c attenuation.
// - Combo gain: d alone high, e alone middle, else low.
// - Input word left-justified, sign in MSB.
// - Unipolar word has three trailing zeros.
// - Bipolar word has four trailing zeros.
// - Output word drops four low bits.
// - Supply LED on when powered and fault-free.
// - Supply state readable by the controller.
// - A channel read starts a fresh conversion only when none is running.
`default_nettype none

module amcf_top
    import amcf_pkg::*;
#(
    parameter int CONV_CYCLES = AMCF_CONV_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  variant_sel,
    input  wire logic        cfg_switch_a,
    input  wire logic        cfg_switch_b,
    input  wire logic        cfg_switch_c,
    input  wire logic        cfg_switch_d,
    input  wire logic        cfg_switch_e,
    input  wire logic        cfg_switch_f,
    input  wire logic        supply_present,
    input  wire logic        supply_fault,
    input  wire logic [11:0] adc_result,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             adc_start,
    output logic [2:0]       adc_chan,
    output logic [11:0]      dac_data,
    output logic             dac_load,
    output logic             supply_good_led,
    output logic             unipolar,
    output logic             range_wide,
    output logic [1:0]       gain_sel,
    output logic [2:0]       atten_sel,
    output logic [7:0]       chan_current,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Number of input channels that a variant really has.
    function automatic logic [3:0] amcf_chan_count(input logic [1:0] v);
        return (v == AMCF_VAR_IN8) ? 4'h8 : 4'h4;
    endfunction : amcf_chan_count

    // ------------------------------------------------------------------
    // Configuration latch and decode
    // ------------------------------------------------------------------
    logic        cfg_taken_r, cfg_taken_nxt;  // Switches captured.
    logic [5:0]  sw_r, sw_nxt;                // Frozen switch copy.
    logic [1:0]  var_r, var_nxt;              // Frozen variant strap.
    logic        uni_nxt, wide_nxt;
    logic [1:0]  gain_nxt;
    logic [2:0]  att_nxt;
    logic [7:0]  cur_nxt;

    // Capture once in the first cycle after reset; decode from the copy
    // only, so a switch bumped in service cannot move the range.
    always_comb begin
        cfg_taken_nxt = 1'b1;
        sw_nxt  = sw_r;
        var_nxt = var_r;
        if (!cfg_taken_r) begin
            sw_nxt  = {cfg_switch_f, cfg_switch_e, cfg_switch_d,
                       cfg_switch_c, cfg_switch_b, cfg_switch_a};
            var_nxt = variant_sel;
        end
        uni_nxt  = 1'b0;
        wide_nxt = 1'b0;
        gain_nxt = AMCF_GAIN_LOW;
        att_nxt  = 3'h0;
        cur_nxt  = 8'h00;
        // One set of range outputs feeds every channel.
        unique case (var_r)
            AMCF_VAR_IN4: begin
                uni_nxt  = sw_r[0];
                wide_nxt = !sw_r[1] && sw_r[2];
            end
            AMCF_VAR_IN8: begin
                uni_nxt  = sw_r[2];
                wide_nxt = !sw_r[3] && sw_r[4];
                cur_nxt[AMCF_CUR_CH_A] = sw_r[0];
                cur_nxt[AMCF_CUR_CH_B] = sw_r[1];
            end
            default: begin
                // Combination part; an unused strap code decodes here too.
                uni_nxt = sw_r[5];
                att_nxt = sw_r[2:0];
                if (sw_r[3] && !sw_r[4]) begin
                    gain_nxt = AMCF_GAIN_HIGH;
                end else if (sw_r[4] && !sw_r[3]) begin
                    gain_nxt = AMCF_GAIN_MID;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_taken_r  <= 1'b0;
            sw_r         <= 6'h00;
            var_r        <= AMCF_VAR_IN4;
            unipolar     <= 1'b0;
            range_wide   <= 1'b0;
            gain_sel     <= AMCF_GAIN_LOW;
            atten_sel    <= 3'h0;
            chan_current <= 8'h00;
        end else begin
            cfg_taken_r  <= cfg_taken_nxt;
            sw_r         <= sw_nxt;
            var_r        <= var_nxt;
            unipolar     <= uni_nxt;
            range_wide   <= wide_nxt;
            gain_sel     <= gain_nxt;
            atten_sel    <= att_nxt;
            chan_current <= cur_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Bus slave, conversion sequencer, output word, supply and events
    // ------------------------------------------------------------------
    amcf_conv_state_type   st_r, st_nxt;          // Conversion state.
    logic [AMCF_CNT_W-1:0] cnt_r, cnt_nxt;        // Cycles into conversion.
    logic [15:0] in_word_r [8];                   // Formatted input words.
    logic [15:0] in_word_nxt [8];
    logic [15:0] out_word_r, out_word_nxt;        // Last output word.
    logic [AMCF_IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_en_r, irq_en_nxt;
    logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [7:0]  aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0]  w_strb_r, w_strb_nxt;
    logic        bvalid_nxt, rvalid_nxt, start_nxt, load_nxt, good_nxt;
    logic [1:0]  bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    logic [2:0]  chan_nxt;
    logic [11:0] dac_nxt;
    logic        conv_end;                        // Last conversion cycle.

    assign conv_end = (st_r == AMCF_ST_CONV) &&
                      (cnt_r == AMCF_CNT_W'(CONV_CYCLES - 1));

    always_comb begin
        logic [AMCF_IRQ_W-1:0] ev;
        logic                  is_in;
        logic [2:0]            idx;
        ev = '0;
        is_in = 1'b0;
        idx = 3'h0;
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        in_word_nxt = in_word_r;
        out_word_nxt = out_word_r;
        irq_en_nxt = irq_en_r;
        irq_stat_nxt = irq_stat_r;
        aw_hold_nxt = aw_hold_r;
        aw_addr_nxt = aw_addr_r;
        w_hold_nxt = w_hold_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = s_axi_bvalid && !s_axi_bready;
        bresp_nxt = s_axi_bresp;
        rvalid_nxt = s_axi_rvalid && !s_axi_rready;
        rresp_nxt = s_axi_rresp;
        rdata_nxt = s_axi_rdata;
        start_nxt = 1'b0;
        load_nxt = 1'b0;
        chan_nxt = adc_chan;
        dac_nxt = dac_data;
        good_nxt = supply_present && !supply_fault;
        if (supply_good_led && !good_nxt) begin
            ev[AMCF_IRQ_SUPPLY] = 1'b1;
        end
        // Address and data are accepted in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        // Perform the write once both halves are held.
        if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = AMCF_RESP_OKAY;
            unique case (aw_addr_r)
                AMCF_OFS_OUT: begin
                    if (w_strb_r[0]) out_word_nxt[7:0] = w_data_r[7:0];
                    if (w_strb_r[1]) out_word_nxt[15:8] = w_data_r[15:8];
                    dac_nxt = out_word_nxt[15:AMCF_DAC_LSB];
                    load_nxt = 1'b1;
                end
                AMCF_OFS_IRQ_CLR: begin
                    if (w_strb_r[0]) begin
                        irq_stat_nxt = irq_stat_r &
                                       ~w_data_r[AMCF_IRQ_W-1:0];
                    end
                end
                AMCF_OFS_IRQ_EN: begin
                    if (w_strb_r[0]) irq_en_nxt = w_data_r[AMCF_IRQ_W-1:0];
                end
                default: bresp_nxt = AMCF_RESP_SLVERR;
            endcase
        end
        // Read: answer one cycle after the address is taken.
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = AMCF_RESP_OKAY;
            rdata_nxt = 32'h0;
            idx = s_axi_araddr[AMCF_IDX_LSB +: 3];
            is_in = (s_axi_araddr >= AMCF_OFS_IN_BASE) &&
                    (s_axi_araddr <= AMCF_OFS_IN_LAST) &&
                    (s_axi_araddr[1:0] == 2'h0);
            if (is_in && ({1'b0, idx} < amcf_chan_count(var_r))) begin
                rdata_nxt[15:0] = in_word_r[idx];
                // A read starts a fresh conversion of that channel when none is running.
                if (st_r == AMCF_ST_IDLE) begin
                    st_nxt = AMCF_ST_CONV;
                    cnt_nxt = '0;
                    chan_nxt = idx;
                    start_nxt = 1'b1;
                end
            end else begin
                unique case (s_axi_araddr)
                    AMCF_OFS_CFG: begin
                        rdata_nxt[AMCF_CFG_SW_LSB +: 6] = sw_r;
                        rdata_nxt[AMCF_CFG_VAR_LSB +: 2] = var_r;
                        rdata_nxt[AMCF_CFG_UNI_BIT] = unipolar;
                        rdata_nxt[AMCF_CFG_WIDE_BIT] = range_wide;
                        rdata_nxt[AMCF_CFG_GAIN_LSB +: 2] = gain_sel;
                        rdata_nxt[AMCF_CFG_ATT_LSB +: 3] = atten_sel;
                        rdata_nxt[AMCF_CFG_CUR_LSB +: 8] = chan_current;
                    end
                    AMCF_OFS_STATUS: begin
                        rdata_nxt[AMCF_ST_SUPPLY] = supply_good_led;
                        rdata_nxt[AMCF_ST_BUSY] = (st_r == AMCF_ST_CONV);
                        rdata_nxt[AMCF_ST_CFG] = cfg_taken_r;
                    end
                    AMCF_OFS_OUT: rdata_nxt[15:0] = out_word_r;
                    AMCF_OFS_IRQ_STAT:
                        rdata_nxt[AMCF_IRQ_W-1:0] = irq_stat_r;
                    AMCF_OFS_IRQ_EN:
                        rdata_nxt[AMCF_IRQ_W-1:0] = irq_en_r;
                    default: rresp_nxt = AMCF_RESP_SLVERR;
                endcase
            end
        end
        // Conversion runs its full time; reads meanwhile start nothing.
        if (st_r == AMCF_ST_CONV) begin
            cnt_nxt = cnt_r + 1'b1;
            if (conv_end) begin
                st_nxt = AMCF_ST_IDLE;
                ev[AMCF_IRQ_CONV] = 1'b1;
                if (unipolar) begin
                    in_word_nxt[adc_chan] = {1'b0, adc_result, 3'h0};
                end else begin
                    in_word_nxt[adc_chan] = {adc_result, 4'h0};
                end
            end
        end
        // A new event wins over a clear in the same cycle.
        irq_stat_nxt = irq_stat_nxt | ev;
    end

    // Ready signals come from flops and depend on held state only.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= AMCF_ST_IDLE;
            cnt_r <= '0;
            for (int i = 0; i < 8; i++) in_word_r[i] <= 16'h0000;
            out_word_r <= 16'h0000;
            irq_stat_r <= '0;
            irq_en_r <= '0;
            aw_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_hold_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AMCF_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= AMCF_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            adc_start <= 1'b0;
            adc_chan <= 3'h0;
            dac_data <= 12'h000;
            dac_load <= 1'b0;
            supply_good_led <= 1'b0;
            irq <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            in_word_r <= in_word_nxt;
            out_word_r <= out_word_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            aw_hold_r <= aw_hold_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_hold_r <= w_hold_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            s_axi_awready <= !aw_hold_nxt && !bvalid_nxt;
            s_axi_wready <= !w_hold_nxt && !bvalid_nxt;
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp <= bresp_nxt;
            s_axi_arready <= !rvalid_nxt;
            s_axi_rvalid <= rvalid_nxt;
            s_axi_rresp <= rresp_nxt;
            s_axi_rdata <= rdata_nxt;
            adc_start <= start_nxt;
            adc_chan <= chan_nxt;
            dac_data <= dac_nxt;
            dac_load <= load_nxt;
            supply_good_led <= good_nxt;
            irq <= |(irq_stat_nxt & irq_en_nxt);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [AMCF_CNT_W-1:0] since_start_r;  // Cycles since adc_start.
    always_ff @(posedge clk) begin
        if (!rst_n || adc_start) since_start_r <= '0;
        else since_start_r <= since_start_r + 1'b1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_cfg_frozen: assert property (cfg_taken_r |=> $stable(sw_r))
        else $error("latched switches changed");
    a_range_in4: assert property ($past(cfg_taken_r) &&
        var_r == AMCF_VAR_IN4 |-> unipolar == sw_r[0] &&
        range_wide == (!sw_r[1] && sw_r[2]))
        else $error("four-input range decode wrong");
    a_range_in8: assert property ($past(cfg_taken_r) &&
        var_r == AMCF_VAR_IN8 |-> unipolar == sw_r[2] &&
        range_wide == (!sw_r[3] && sw_r[4]))
        else $error("eight-input range decode wrong");
    a_current_in8: assert property ($past(cfg_taken_r) &&
        var_r == AMCF_VAR_IN8 |-> chan_current == {sw_r[1:0], 6'h00})
        else $error("current mode select wrong");
    a_combo_gain: assert property ($past(cfg_taken_r) &&
        var_r == AMCF_VAR_COMBO && sw_r[3] && !sw_r[4]
        |-> gain_sel == AMCF_GAIN_HIGH && atten_sel == sw_r[2:0])
        else $error("combination gain decode wrong");
    a_uni_word: assert property (conv_end && unipolar
        |=> in_word_r[adc_chan] == {1'b0, $past(adc_result), 3'h0})
        else $error("unipolar input word wrong");
    a_bi_word: assert property (conv_end && !unipolar
        |=> in_word_r[adc_chan][15:4] == $past(adc_result) &&
        in_word_r[adc_chan][3:0] == 4'h0)
        else $error("bipolar input word wrong");
    a_dac_drop: assert property (dac_load
        |-> dac_data == out_word_r[15:AMCF_DAC_LSB])
        else $error("output word not truncated");
    a_led_follow: assert property ($past(rst_n) |->
        supply_good_led == $past(supply_present && !supply_fault))
        else $error("supply indicator wrong");
    a_conv_time: assert property (conv_end
        |-> since_start_r == AMCF_CNT_W'(CONV_CYCLES - 2))
        else $error("conversion time wrong");
    a_irq_level: assert property (irq == |(irq_stat_r & irq_en_r))
        else $error("interrupt level wrong");

    c_conv_done: cover property (conv_end ##1 irq_stat_r[AMCF_IRQ_CONV]);
    c_dac_write: cover property (dac_load);
    c_supply_lost: cover property ($fell(supply_good_led));

endmodule : amcf_top

`default_nettype wire

//--- tb.sv
/* Self-checking bench for amcf_top: decode, word format, supply, irq.
   Assumes amcf_pkg and amcf_adc_model are compiled first. */
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin \
    miscompares++; $display("mismatch t=%0t got=%h exp=%h", $time, \
    (a), (e)); end end
module tb
    import amcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [1:0] v;  logic [5:0] s;  logic [14:0] e;  logic [14:0] m;
    } amcf_row_type;
    // Strap, switches {f..a}, expected decode and the fields compared.
    localparam amcf_row_type ROWS [8] = '{
        '{2'h0, 6'h05, 15'h6000, 15'h60ff}, '{2'h0, 6'h02, 15'h0000, 15'h60ff},
        '{2'h1, 6'h15, 15'h6040, 15'h60ff}, '{2'h1, 6'h0a, 15'h0080, 15'h60ff},
        '{2'h2, 6'h29, 15'h5100, 15'h7fff}, '{2'h2, 6'h14, 15'h0c00, 15'h7fff},
        '{2'h2, 6'h02, 15'h0200, 15'h7fff}, '{2'h0, 6'h04, 15'h2000, 15'h60ff}};
    logic clk = 1'b0, rst_n = 1'b0, pres = 1'b1, flt = 1'b0;
    logic [1:0] vs = 2'h0, r;
    logic [5:0] sw = 6'h00;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, d, rdat;
    logic awv = 1'b0, wv = 1'b0, bri = 1'b0, arv = 1'b0, rri = 1'b0;
    logic awr, wrd, bv, arr, rv, st, led, uni, wide, irq, ld;
    logic [1:0] br, rr, gain;
    logic [2:0] ch, att;
    logic [11:0] adc, dac;
    logic [7:0] cur;
    int checked = 0, miscompares = 0, i, n, sum, loads = 0;
    wire logic [14:0] act = {uni, wide, gain, att, cur};
    amcf_adc_model #(.CONV(8)) i_adc (.clk(clk), .adc_start(st),
        .adc_chan(ch), .adc_result(adc));
    amcf_top #(.CONV_CYCLES(8)) i_dut (.clk(clk), .rst_n(rst_n),
        .variant_sel(vs), .cfg_switch_a(sw[0]), .cfg_switch_b(sw[1]),
        .cfg_switch_c(sw[2]), .cfg_switch_d(sw[3]), .cfg_switch_e(sw[4]),
        .cfg_switch_f(sw[5]), .supply_present(pres), .supply_fault(flt),
        .adc_result(adc), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bri), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rri),
        .adc_start(st), .adc_chan(ch), .dac_data(dac), .dac_load(ld),
        .supply_good_led(led), .unipolar(uni), .range_wide(wide),
        .gain_sel(gain), .atten_sel(att), .chan_current(cur), .irq(irq));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Count converter load strobes so that each write can be audited.
    always @(posedge clk) begin
        if (ld) loads <= loads + 1;
    end
    task automatic close_out();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic give_up();
        miscompares++;
        close_out();
    endtask : give_up
    // Reset with new straps; decode is valid two edges after release.
    task automatic boot(input logic [1:0] v, input logic [5:0] s);
        @(posedge clk);
        vs <= v;
        sw <= s;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : boot
    // Readys are sampled at the falling edge, as they stand for the rise.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tr;
        @(posedge clk);
        {awa, wd, awv, wv, bri} <= {a, v, 3'b111};
        for (n = 0; n < 99; n++) begin
            @(negedge clk);
            {ta, tw, tr, r} = {awr & awv, wrd & wv, bv, br};
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tr) break;
        end
        bri <= 1'b0;
        if (n == 99) give_up();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ta, tv;
        @(posedge clk);
        {ara, arv, rri} <= {a, 2'b11};
        for (n = 0; n < 99; n++) begin
            @(negedge clk);
            {ta, tv, d, r} = {arr, rv, rdat, rr};
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (tv) break;
        end
        rri <= 1'b0;
        if (n == 99) give_up();
    endtask : rd
    initial begin
        for (i = 0; i < 8; i++) begin
            boot(ROWS[i].v, ROWS[i].s);
            @(negedge clk);
            `CHK(act & ROWS[i].m, ROWS[i].e)
        end
        // Later switch moves must not reach the decode.
        @(posedge clk);
        sw <= 6'h3f;
        repeat (3) @(negedge clk);
        `CHK(act & 15'h60ff, 15'h2000)
        `CHK(led, 1'b1)
        rd(AMCF_OFS_STATUS);
        `CHK(d[AMCF_ST_SUPPLY], 1'b1)
        rd(8'h18);
        `CHK(r, AMCF_RESP_SLVERR)
        wr(AMCF_OFS_OUT, 32'h0000abcf);
        `CHK(dac, 12'habc)
        `CHK(r, AMCF_RESP_OKAY)
        wr(AMCF_OFS_IRQ_EN, 32'h1);
        `CHK(loads, 1)
        rd(AMCF_OFS_IN_BASE);
        for (n = 0; n < 99 && irq !== 1'b1; n++) @(negedge clk);
        if (n == 99) give_up();
        wr(AMCF_OFS_IRQ_CLR, 32'h1);
        wr(AMCF_OFS_IRQ_EN, 32'h0);
        `CHK(irq, 1'b0)
        rd(AMCF_OFS_IN_BASE);
        `CHK(d[15:0], 16'h1a50)
        repeat (20) @(negedge clk);
        `CHK(irq, 1'b0)
        rd(AMCF_OFS_IRQ_STAT);
        `CHK(d[0], 1'b1)
        flt <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK(led, 1'b0)
        rd(AMCF_OFS_IRQ_STAT);
        `CHK(d[AMCF_IRQ_SUPPLY], 1'b1)
        // Unipolar boot; the controller averages 64 fresh readings.
        boot(2'h0, 6'h05);
        rd(AMCF_OFS_IN_BASE + 8'h04);
        sum = 0;
        for (i = 0; i < 64; i++) begin
            repeat (12) @(negedge clk);
            rd(AMCF_OFS_IN_BASE + 8'h04);
            sum += d[15:0];
        end
        `CHK(sum, 64 * 32'h1d28)
        `CHK(d[15:0], 16'h1d28)
        close_out();
    end
endmodule : tb
`default_nettype wire
